// *** dcb_pkg.sv ***
// Constants and types for the dual channel buffer controller
package dcb_pkg;
    localparam int DCB_WIDTH = 16;
    localparam int DCB_NLOAD = 4;
    localparam int DCB_NDISC = 4;
    localparam int DCB_NRST = 3;
    localparam int DCB_NRESP = 4;
    localparam int DCB_NCHAN = 2;
    // Strobe hold time in ns, so the device sees a full assertion
    localparam int DCB_STROBE_NS = 8;
    localparam int DCB_CLK_NS = 4;
    localparam int DCB_STROBE_CYC = (DCB_STROBE_NS + DCB_CLK_NS - 1) / DCB_CLK_NS;
    localparam logic [3:0] DCB_CNT_RST = 4'h0;
    localparam logic [15:0] DCB_DATA_RST = 16'h0000;
    typedef enum logic [1:0] {
        DCB_IDLE = 2'b00,
        DCB_PULSE = 2'b01,
        DCB_WAIT = 2'b11,
        DCB_GAP = 2'b10
    } dcb_state_e;
endpackage : dcb_pkg

// *** dcb_host.sv ***
// Host-side controller for one writer and one reader channel of the buffer
`timescale 1ns/100ps
// How it works
// - Unused disconnect group must hold one strobe low.
// - Unused reset group must hold one strobe low.
// - Reader waits for data-valid, reads, then gives a full response.
// - Use disconnect to load silently and drop read-ack.
module dcb_host
    import dcb_pkg::*;
#(
    parameter int WIDTH = DCB_WIDTH
) (
    input wire logic MCLK,
    input wire logic SRST,
    // Writer side: words to send into channel 0
    input wire logic [WIDTH-1:0] WR_DATA,
    input wire logic WR_SILENT,
    input wire logic WR_VALID,
    output logic WR_READY,
    // Device pins, channel 0 (written by us)
    output logic [WIDTH-1:0] DEV_IN_DATA,
    output logic [DCB_NLOAD-1:0] DEV_LOAD,
    output logic [DCB_NDISC-1:0] DEV_DISC,
    output logic [DCB_NRST-1:0] DEV_RST,
    input wire logic DEV_READ_ACK_FLAG,
    // Device pins, channel 1 (read by us)
    input wire logic [WIDTH-1:0] DEV_OUT_DATA,
    input wire logic DEV_DATA_VALID_FLAG,
    output logic [DCB_NRESP-1:0] DEV_RESP,
    // Reader side: words taken from channel 1
    output logic [WIDTH-1:0] RD_DATA,
    output logic RD_VALID,
    input wire logic RD_READY
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] dcb_inc(input logic [3:0] v);
        dcb_inc = v + 4'h1;
    endfunction : dcb_inc

    // Strobe width rounds up to whole clocks, never shorter than asked
    localparam logic [3:0] HOLD = 4'(DCB_STROBE_CYC);

    // ----------------------------------------------------------------
    // Writer: drive load or disconnect strobes
    // ----------------------------------------------------------------
    dcb_state_e w_state_r;
    logic [3:0] w_cnt_r;
    logic w_silent_r;
    logic w_first_r;

    // Acceptance: first word and any word after a silent load free, others wait for read-ack
    // writer waits for consumption
    // One-cycle pulse so a held valid is taken only once
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            WR_READY <= 1'b0;
        end else begin
            WR_READY <= (w_state_r == DCB_IDLE) && !WR_READY &&
                        (w_first_r || DEV_READ_ACK_FLAG);
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            w_state_r <= DCB_IDLE;
            w_cnt_r <= DCB_CNT_RST;
            w_silent_r <= 1'b0;
            w_first_r <= 1'b1;
            DEV_IN_DATA <= DCB_DATA_RST;
            DEV_LOAD <= '0;
            DEV_DISC <= '0;
        end else begin
            unique case (w_state_r)
                DCB_IDLE: begin
                    if (WR_VALID && WR_READY) begin
                        DEV_IN_DATA <= WR_DATA;
                        w_silent_r <= WR_SILENT;
                        w_cnt_r <= DCB_CNT_RST;
                        w_state_r <= DCB_PULSE;
                    end
                end
                DCB_PULSE: begin
                    if (w_silent_r) begin
                        DEV_DISC <= '1;
                    end else begin
                        DEV_LOAD <= '1;
                    end
                    w_cnt_r <= dcb_inc(w_cnt_r);
                    if (w_cnt_r == HOLD) begin
                        w_state_r <= DCB_WAIT;
                    end
                end
                DCB_WAIT: begin
                    DEV_LOAD <= '0;
                    DEV_DISC <= '0;
                    w_first_r <= w_silent_r;
                    w_state_r <= DCB_GAP;
                end
                DCB_GAP: begin
                    // Let read-ack clear first, else a stale ack re-accepts
                    if (!DEV_READ_ACK_FLAG || w_silent_r) begin
                        w_state_r <= DCB_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reader with two-entry skid buffer
    // ----------------------------------------------------------------
    dcb_state_e r_state_r;
    logic [3:0] r_cnt_r;
    logic [WIDTH-1:0] buf_mem [0:1];
    logic buf_wp_r;
    logic buf_rp_r;
    logic [1:0] buf_cnt_r;
    logic push;
    logic pop;

    // Buffer full stalls reading, so no word is lost
    assign push = (r_state_r == DCB_IDLE) && DEV_DATA_VALID_FLAG && (buf_cnt_r != 2'h2);
    assign pop = RD_VALID && RD_READY;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            r_state_r <= DCB_IDLE;
            r_cnt_r <= DCB_CNT_RST;
            DEV_RESP <= '0;
        end else begin
            unique case (r_state_r)
                DCB_IDLE: begin
                    if (push) begin
                        r_cnt_r <= DCB_CNT_RST;
                        r_state_r <= DCB_PULSE;
                    end
                end
                DCB_PULSE: begin
                    DEV_RESP <= '1;
                    r_cnt_r <= dcb_inc(r_cnt_r);
                    if (r_cnt_r == HOLD) begin
                        r_state_r <= DCB_WAIT;
                    end
                end
                DCB_WAIT: begin
                    DEV_RESP <= '0;
                    r_state_r <= DCB_GAP;
                end
                DCB_GAP: begin
                    // Wait for data-valid to drop, else one word is taken twice
                    if (!DEV_DATA_VALID_FLAG) begin
                        r_state_r <= DCB_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (push) begin
            buf_mem[buf_wp_r] <= DEV_OUT_DATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            buf_cnt_r <= 2'd0;
        end else begin
            if (push) begin
                buf_wp_r <= ~buf_wp_r;
            end
            if (pop) begin
                buf_rp_r <= ~buf_rp_r;
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------------------------------
    // Registered output stage fed from the buffer
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            RD_VALID <= 1'b0;
            RD_DATA <= DCB_DATA_RST;
        end else begin
            RD_VALID <= (buf_cnt_r - {1'b0, pop}) != 2'h0;
            RD_DATA <= pop ? buf_mem[~buf_rp_r] : buf_mem[buf_rp_r];
        end
    end

    // ----------------------------------------------------------------
    // Unused reset strobe group
    // ----------------------------------------------------------------
    // reset group held low
    // Read-ack is cleared through disconnect instead
    always_ff @(posedge MCLK) begin
        DEV_RST <= '0;
    end
endmodule : dcb_host

// *** dcb_chan_model.sv ***
// Behavioural model of one buffer channel of the device
`timescale 1ns/100ps
module dcb_chan_model (
    input logic clk, input logic rst, input logic [15:0] din,
    input logic [3:0] ld, input logic [3:0] dc, input logic [2:0] rs, input logic [3:0] rp,
    output logic [15:0] dout, output logic dv, output logic ack
);
    logic l_r, p_r;
    // strobe groups ANDed, sampled on clock
    wire l_all = &ld;
    wire c_all = (&dc) | (&rs);
    wire p_all = &rp;
    always_ff @(posedge clk) begin
        if (rst) begin
            {dout, dv, ack, l_r, p_r} <= '0;
        end else begin
            l_r <= l_all;
            p_r <= p_all;
            if (l_all | c_all) begin
                dout <= din;
                ack <= 1'b0;
            end
            // Response strobe wins over a load release
            if (l_r & !l_all) dv <= 1'b1;
            if (p_all) dv <= 1'b0;
            if (p_r & !p_all) ack <= 1'b1;
        end
    end
endmodule : dcb_chan_model

// *** dcb_host_props.sv ***
// Concurrent checks on the host controller ports
`timescale 1ns/100ps
module dcb_host_props (
    input logic MCLK, input logic SRST, input logic WR_SILENT, input logic WR_VALID,
    input logic WR_READY, input logic [15:0] DEV_IN_DATA, input logic [3:0] DEV_LOAD,
    input logic [3:0] DEV_DISC, input logic [2:0] DEV_RST, input logic DEV_DATA_VALID_FLAG,
    input logic [15:0] DEV_OUT_DATA, input logic [3:0] DEV_RESP, input logic [15:0] RD_DATA,
    input logic RD_VALID, input logic RD_READY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    chk_reset_quiet: assert property (disable iff (1'b0) SRST |=> !RD_VALID &&
        DEV_LOAD == 4'h0 && DEV_RESP == 4'h0) else $error("outputs busy after reset");
    chk_load_shape: assert property (WR_VALID && WR_READY && !WR_SILENT |->
        ##2 (DEV_LOAD == 4'hF) [*3] ##1 DEV_LOAD == 4'h0) else $error("bad load strobe");
    chk_disc_shape: assert property (WR_VALID && WR_READY && WR_SILENT |->
        ##2 (DEV_DISC == 4'hF) [*3] ##1 DEV_DISC == 4'h0) else $error("bad disc strobe");
    chk_data_steady: assert property (DEV_LOAD == 4'hF || DEV_DISC == 4'hF |->
        $stable(DEV_IN_DATA)) else $error("data moved under strobe");
    chk_reset_grp: assert property (DEV_RST == 3'h0) else $error("reset group active");
    chk_resp_shape: assert property ($rose(DEV_RESP == 4'hF) |-> $past(DEV_DATA_VALID_FLAG)
        ##0 (DEV_RESP == 4'hF) [*3] ##1 DEV_RESP == 4'h0) else $error("bad response");
    chk_rd_word: assert property ($rose(RD_VALID) |->
        RD_DATA == $past(DEV_OUT_DATA, 2)) else $error("wrong word read");
    chk_rd_hold: assert property (RD_VALID && !RD_READY |=>
        RD_VALID && $stable(RD_DATA)) else $error("read word dropped");
    chk_wr_pulse: assert property (WR_READY |=> !WR_READY) else $error("ready too long");
endmodule : dcb_host_props
bind dcb_host dcb_host_props u_props (
    .MCLK(MCLK),
    .SRST(SRST),
    .WR_SILENT(WR_SILENT),
    .WR_VALID(WR_VALID),
    .WR_READY(WR_READY),
    .DEV_IN_DATA(DEV_IN_DATA),
    .DEV_LOAD(DEV_LOAD),
    .DEV_DISC(DEV_DISC),
    .DEV_RST(DEV_RST),
    .DEV_DATA_VALID_FLAG(DEV_DATA_VALID_FLAG),
    .DEV_OUT_DATA(DEV_OUT_DATA),
    .DEV_RESP(DEV_RESP),
    .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID),
    .RD_READY(RD_READY)
);

// *** tb.sv ***
// Bench for the host controller against two channel models
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst = 1, ws = 0, wv = 0, rr = 0, wrdy, rv, dv0, ak0, dv1, ak1;
    logic [15:0] wd = 16'h0000, d1 = 16'h0000, q0, q1, rd, dio;
    logic [3:0] rp0 = 4'h0, ld1 = 4'h0, ld0, dc0, rp1;
    logic [2:0] rs0;
    int err_total = 0, samples_checked = 0, n;
    initial forever #2 clk = ~clk;
    dcb_host u_dcb_host (.MCLK(clk), .SRST(rst), .WR_DATA(wd), .WR_SILENT(ws), .WR_VALID(wv),
        .WR_READY(wrdy), .DEV_IN_DATA(dio), .DEV_LOAD(ld0), .DEV_DISC(dc0), .DEV_RST(rs0),
        .DEV_READ_ACK_FLAG(ak0), .DEV_OUT_DATA(q1), .DEV_DATA_VALID_FLAG(dv1),
        .DEV_RESP(rp1), .RD_DATA(rd), .RD_VALID(rv), .RD_READY(rr));
    dcb_chan_model m_ch0 (.clk(clk), .rst(rst), .din(dio), .ld(ld0), .dc(dc0), .rs(rs0),
        .rp(rp0), .dout(q0), .dv(dv0), .ack(ak0));
    // unused groups of our writer held low
    dcb_chan_model m_ch1 (.clk(clk), .rst(rst), .din(d1), .ld(ld1), .dc(4'h0), .rs(3'h0),
        .rp(rp1), .dout(q1), .dv(dv1), .ack(ak1));
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task lim;
        if (n >= 99) begin
            err_total++;
            $display("MISMATCH %0t wait ran out", $time);
            report_and_stop();
        end
    endtask : lim
    task put(input logic [15:0] w, input logic s);
        {wd, ws, wv} = {w, s, 1'b1};
        for (n = 0; wrdy !== 1'b1 && n < 99; n++) @(negedge clk);
        lim();
        @(negedge clk);
        wv = 0;
        repeat (6) @(negedge clk);
    endtask : put
    task test_load(input logic [15:0] w);
        put(w, 0);
        cmp(q0, w);
        cmp(ak0, 0);
        cmp(dv0, 1);
        rp0 = 4'hF;
        repeat (2) @(negedge clk);
        rp0 = 4'h0;
        repeat (2) @(negedge clk);
        cmp(dv0, 0);
        cmp(ak0, 1);
        $display("test_load done");
    endtask : test_load
    task test_silent;
        put(16'h3C5A, 1);
        cmp(q0, 16'h3C5A);
        cmp(dv0, 0);
        cmp(ak0, 0);
        $display("test_silent done");
    endtask : test_silent
    task push1(input logic [15:0] w);
        {d1, ld1} = {w, 4'hF};
        repeat (3) @(negedge clk);
        ld1 = 4'h0;
        for (n = 0; ak1 !== 1'b1 && n < 99; n++) @(negedge clk);
    endtask : push1
    task pop(input logic [15:0] w);
        for (n = 0; rv !== 1'b1 && n < 99; n++) @(negedge clk);
        lim();
        cmp(rd, w);
        rr = 1;
        @(negedge clk);
        rr = 0;
        @(negedge clk);
    endtask : pop
    task test_read;
        push1(16'h1111);
        lim();
        push1(16'h2222);
        lim();
        push1(16'h3333);
        cmp(ak1, 0);
        cmp(dv1, 1);
        pop(16'h1111);
        pop(16'h2222);
        pop(16'h3333);
        $display("test_read done");
    endtask : test_read
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        test_load(16'hA5C3);
        test_silent();
        test_load(16'h0FF0);
        test_read();
        report_and_stop();
    end
endmodule : tb
